// [hdl/sst_eptr.sv]
`timescale 1ns/1ps
// spill pointer: one word up per spilled word, one down per filled word
module sst_eptr #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         inc,
  input  wire logic         dec,
  output logic      [W-1:0] value
);
  logic [W-1:0] ptr_ff;
  logic [W-1:0] nxt_ptr;

  initial begin
    if (W < 2) $error("sst_eptr: width too small");
  end

  // next pointer; inc and dec never coincide
  always_comb begin
    nxt_ptr = ptr_ff;
    if (inc) begin
      nxt_ptr = ptr_ff + W'(1);
    end else if (dec) begin
      nxt_ptr = ptr_ff - W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  assign value = ptr_ff;
endmodule

// [hdl/sst_pkg.sv]
package sst_pkg;
  localparam int HALF_W    = 24;
  localparam int ENTRY_W   = 48;
  localparam int DEPTH     = 16;
  localparam int SLOT_W    = 4;
  localparam int IDX_W     = 24;
  localparam int OCC_W     = 5;
  // usable entries when the extension is off
  localparam logic [IDX_W-1:0] NOEXT_MAX = 24'h00000f;
  // on-chip fill level kept after a spill; leaves room for a two-entry loop push
  localparam logic [OCC_W-1:0] ONCHIP_HI = 5'h0e;
  localparam logic [IDX_W-1:0] IDX_RST   = 24'h000000;
  localparam logic [OCC_W-1:0] OCC_RST   = 5'h00;

  typedef enum logic [2:0] {
    OP_CALL     = 3'h0,
    OP_RET_SUB  = 3'h1,
    OP_RET_INT  = 3'h2,
    OP_LOOP     = 3'h3,
    OP_WR_HIGH  = 3'h4,
    OP_RD_HIGH  = 3'h5,
    OP_WR_LOW   = 3'h6,
    OP_RD_LOW   = 3'h7
  } sst_op_e;

  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_LOOP2    = 7'h02,
    S_SPILL_LD = 7'h04,
    S_SPILL_HI = 7'h08,
    S_SPILL_LO = 7'h10,
    S_FILL_LO  = 7'h20,
    S_FILL_HI  = 7'h40
  } sst_state_e;
endpackage

// [hdl/sst_ram.sv]
`timescale 1ns/1ps
// on-chip stack store, halves written separately, read is combinational
module sst_ram (
  input wire logic clk,
  sst_ram_if.mem   rp
);
  logic [sst_pkg::HALF_W-1:0] hi_mem [sst_pkg::DEPTH];
  logic [sst_pkg::HALF_W-1:0] lo_mem [sst_pkg::DEPTH];

  // no reset on the array: contents are only meaningful at and below the index
  always_ff @(posedge clk) begin
    if (rp.we_hi) begin
      hi_mem[rp.waddr] <= rp.whi;
    end
    if (rp.we_lo) begin
      lo_mem[rp.waddr] <= rp.wlo;
    end
  end

  assign rp.rhi = hi_mem[rp.raddr];
  assign rp.rlo = lo_mem[rp.raddr];
endmodule

// [hdl/sst_ram_if.sv]
`timescale 1ns/1ps
interface sst_ram_if;
  logic [sst_pkg::SLOT_W-1:0] raddr;
  logic [sst_pkg::HALF_W-1:0] rhi;
  logic [sst_pkg::HALF_W-1:0] rlo;
  logic [sst_pkg::SLOT_W-1:0] waddr;
  logic                       we_hi;
  logic                       we_lo;
  logic [sst_pkg::HALF_W-1:0] whi;
  logic [sst_pkg::HALF_W-1:0] wlo;
  modport ctl (output raddr, waddr, we_hi, we_lo, whi, wlo, input rhi, rlo);
  modport mem (input raddr, waddr, we_hi, we_lo, whi, wlo, output rhi, rlo);
endinterface

// [hdl/sst_stack.sv]
`timescale 1ns/1ps
module sst_stack (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  output logic             op_ready,
  input  wire logic [23:0] program_counter_in,
  input  wire logic [23:0] status_word_in,
  input  wire logic [23:0] loop_count_in,
  input  wire logic [23:0] loop_end_address_in,
  input  wire logic [23:0] move_data_in,
  output logic [23:0]      program_counter_out,
  output logic             program_counter_load,
  output logic [23:0]      status_word_out,
  output logic             status_word_load,
  output logic [23:0]      move_data_out,
  output logic             move_data_valid,
  input  wire logic        spill_enable_bit,
  input  wire logic        spill_memory_select,
  input  wire logic [23:0] stack_size_reg,
  output logic [23:0]      top_of_stack_index,
  output logic             stack_error,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_space_y,
  output logic [23:0]      mem_addr,
  output logic [23:0]      mem_wdata,
  input  wire logic [23:0] mem_rdata,
  input  wire logic        mem_ack
);
  localparam int HW = sst_pkg::HALF_W;
  localparam int IW = sst_pkg::IDX_W;
  localparam int OW = sst_pkg::OCC_W;
  localparam int SW = sst_pkg::SLOT_W;

  sst_ram_if rif ();

  sst_pkg::sst_state_e     state_ff;
  sst_pkg::sst_state_e     nxt_state;
  sst_pkg::sst_op_e        op;
  logic [IW-1:0]           idx_ff;
  logic [IW-1:0]           nxt_idx;
  logic [OW-1:0]           occ_ff;
  logic [OW-1:0]           nxt_occ;
  logic [sst_pkg::ENTRY_W-1:0] ent_ff;
  logic [sst_pkg::ENTRY_W-1:0] nxt_ent;
  logic [HW-1:0]           pc_ff;
  logic [HW-1:0]           nxt_pc;
  logic [HW-1:0]           stw_ff;
  logic [HW-1:0]           nxt_stw;
  logic [HW-1:0]           md_ff;
  logic [HW-1:0]           nxt_md;
  logic                    pcl_ff;
  logic                    nxt_pcl;
  logic                    stl_ff;
  logic                    nxt_stl;
  logic                    mdv_ff;
  logic                    nxt_mdv;
  logic                    err_ff;
  logic                    nxt_err;
  logic                    ep_inc;
  logic                    ep_dec;
  logic [HW-1:0]           ep_val;

  // push limit: fixed fifteen without extension, size register with it
  function automatic logic over_limit(input logic [IW-1:0] idx,
                                      input logic [IW-1:0] n,
                                      input logic          ext,
                                      input logic [IW-1:0] lim);
    logic [IW:0] sum;
    sum = {1'b0, idx} + {1'b0, n};
    if (ext) begin
      over_limit = sum > {1'b0, lim};
    end else begin
      over_limit = sum > {1'b0, sst_pkg::NOEXT_MAX};
    end
  endfunction

  // stack slot of an index: ring of sixteen
  function automatic logic [SW-1:0] slot(input logic [IW-1:0] idx);
    slot = idx[SW-1:0];
  endfunction

  assign op = sst_pkg::sst_op_e'(op_code);

  sst_ram u_ram (
    .clk (clk),
    .rp  (rif.mem)
  );

  sst_eptr #(
    .W (HW)
  ) u_eptr (
    .clk    (clk),
    .arst_n (arst_n),
    .inc    (ep_inc),
    .dec    (ep_dec),
    .value  (ep_val)
  );

  // sequencer handshake and memory strobes decode from state
  assign op_ready    = (state_ff == sst_pkg::S_IDLE);
  assign mem_req     = (state_ff == sst_pkg::S_SPILL_HI) || (state_ff == sst_pkg::S_SPILL_LO) ||
                       (state_ff == sst_pkg::S_FILL_LO) || (state_ff == sst_pkg::S_FILL_HI);
  assign mem_we      = (state_ff == sst_pkg::S_SPILL_HI) || (state_ff == sst_pkg::S_SPILL_LO);
  assign mem_space_y = spill_memory_select;
  // fill reads the word below the pointer, spill writes at it
  assign mem_addr    = mem_we ? ep_val : ep_val - HW'(1);
  assign mem_wdata   = (state_ff == sst_pkg::S_SPILL_HI) ? ent_ff[2*HW-1:HW] : ent_ff[HW-1:0];

  assign top_of_stack_index   = idx_ff;
  assign program_counter_out  = pc_ff;
  assign program_counter_load = pcl_ff;
  assign status_word_out      = stw_ff;
  assign status_word_load     = stl_ff;
  assign move_data_out        = md_ff;
  assign move_data_valid      = mdv_ff;
  assign stack_error          = err_ff;

  // next-state logic for the whole stack controller
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_occ   = occ_ff;
    nxt_ent   = ent_ff;
    nxt_pc    = pc_ff;
    nxt_stw   = stw_ff;
    nxt_md    = md_ff;
    nxt_pcl   = 1'b0;
    nxt_stl   = 1'b0;
    nxt_mdv   = 1'b0;
    nxt_err   = 1'b0;
    ep_inc    = 1'b0;
    ep_dec    = 1'b0;
    rif.raddr = slot(idx_ff);
    rif.waddr = slot(idx_ff + IW'(1));
    rif.we_hi = 1'b0;
    rif.we_lo = 1'b0;
    rif.whi   = program_counter_in;
    rif.wlo   = status_word_in;
    unique case (state_ff)
      sst_pkg::S_IDLE: begin
        if (op_valid) begin
          unique case (op)
            sst_pkg::OP_CALL, sst_pkg::OP_WR_HIGH, sst_pkg::OP_LOOP: begin
              if (over_limit(idx_ff, (op == sst_pkg::OP_LOOP) ? IW'(2) : IW'(1),
                             spill_enable_bit, stack_size_reg)) begin
                nxt_err = 1'b1;
              end else begin
                // increment first, then write the new top
                nxt_idx   = idx_ff + IW'(1);
                nxt_occ   = occ_ff + OW'(1);
                rif.we_hi = 1'b1;
                rif.we_lo = (op != sst_pkg::OP_WR_HIGH);
                if (op == sst_pkg::OP_WR_HIGH) begin
                  rif.whi = move_data_in;
                end else if (op == sst_pkg::OP_LOOP) begin
                  rif.whi = loop_end_address_in;
                  rif.wlo = loop_count_in;
                  nxt_ent = {program_counter_in, status_word_in};
                end
                if (op == sst_pkg::OP_LOOP) begin
                  nxt_state = sst_pkg::S_LOOP2;
                end else if (spill_enable_bit && (occ_ff + OW'(1) > sst_pkg::ONCHIP_HI)) begin
                  nxt_state = sst_pkg::S_SPILL_LD;
                end
              end
            end
            sst_pkg::OP_RET_SUB, sst_pkg::OP_RET_INT, sst_pkg::OP_RD_HIGH: begin
              if (idx_ff == sst_pkg::IDX_RST) begin
                nxt_err = 1'b1;
              end else begin
                // read the top, then decrement
                nxt_idx = idx_ff - IW'(1);
                nxt_occ = occ_ff - OW'(1);
                if (op == sst_pkg::OP_RD_HIGH) begin
                  nxt_md  = rif.rhi;
                  nxt_mdv = 1'b1;
                end else begin
                  nxt_pc  = rif.rhi;
                  nxt_pcl = 1'b1;
                end
                if (op == sst_pkg::OP_RET_INT) begin
                  nxt_stw = rif.rlo;
                  nxt_stl = 1'b1;
                end
                if (spill_enable_bit && (occ_ff == OW'(1)) && (idx_ff != IW'(1))) begin
                  nxt_state = sst_pkg::S_FILL_LO;
                end
              end
            end
            sst_pkg::OP_WR_LOW: begin
              rif.waddr = slot(idx_ff);
              rif.we_lo = 1'b1;
              rif.wlo   = move_data_in;
            end
            sst_pkg::OP_RD_LOW: begin
              nxt_md  = rif.rlo;
              nxt_mdv = 1'b1;
            end
          endcase
        end
      end
      sst_pkg::S_LOOP2: begin
        // second loop entry goes above the first
        nxt_idx   = idx_ff + IW'(1);
        nxt_occ   = occ_ff + OW'(1);
        rif.we_hi = 1'b1;
        rif.we_lo = 1'b1;
        rif.whi   = ent_ff[2*HW-1:HW];
        rif.wlo   = ent_ff[HW-1:0];
        if (spill_enable_bit && (occ_ff + OW'(1) > sst_pkg::ONCHIP_HI)) begin
          nxt_state = sst_pkg::S_SPILL_LD;
        end else begin
          nxt_state = sst_pkg::S_IDLE;
        end
      end
      sst_pkg::S_SPILL_LD: begin
        // oldest on-chip entry sits occ-1 below the top
        rif.raddr = slot(idx_ff - IW'(occ_ff) + IW'(1));
        nxt_ent   = {rif.rhi, rif.rlo};
        nxt_state = sst_pkg::S_SPILL_HI;
      end
      sst_pkg::S_SPILL_HI: begin
        if (mem_ack) begin
          ep_inc    = 1'b1;
          nxt_state = sst_pkg::S_SPILL_LO;
        end
      end
      sst_pkg::S_SPILL_LO: begin
        if (mem_ack) begin
          ep_inc  = 1'b1;
          nxt_occ = occ_ff - OW'(1);
          // a loop push can leave two entries to move
          if (occ_ff - OW'(1) > sst_pkg::ONCHIP_HI) begin
            nxt_state = sst_pkg::S_SPILL_LD;
          end else begin
            nxt_state = sst_pkg::S_IDLE;
          end
        end
      end
      sst_pkg::S_FILL_LO: begin
        rif.waddr = slot(idx_ff);
        rif.wlo   = mem_rdata;
        if (mem_ack) begin
          rif.we_lo = 1'b1;
          ep_dec    = 1'b1;
          nxt_state = sst_pkg::S_FILL_HI;
        end
      end
      sst_pkg::S_FILL_HI: begin
        rif.waddr = slot(idx_ff);
        rif.whi   = mem_rdata;
        if (mem_ack) begin
          rif.we_hi = 1'b1;
          ep_dec    = 1'b1;
          nxt_occ   = occ_ff + OW'(1);
          nxt_state = sst_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_state = sst_pkg::S_IDLE;
      end
    endcase
  end

  // registers only; reset leaves the stack empty
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sst_pkg::S_IDLE;
      idx_ff   <= sst_pkg::IDX_RST;
      occ_ff   <= sst_pkg::OCC_RST;
      ent_ff   <= '0;
      pc_ff    <= '0;
      stw_ff   <= '0;
      md_ff    <= '0;
      pcl_ff   <= 1'b0;
      stl_ff   <= 1'b0;
      mdv_ff   <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      occ_ff   <= nxt_occ;
      ent_ff   <= nxt_ent;
      pc_ff    <= nxt_pc;
      stw_ff   <= nxt_stw;
      md_ff    <= nxt_md;
      pcl_ff   <= nxt_pcl;
      stl_ff   <= nxt_stl;
      mdv_ff   <= nxt_mdv;
      err_ff   <= nxt_err;
    end
  end
endmodule

// [tb/sst_mem_model.sv]
`timescale 1ns/1ps
// data memory beside the stack; each word is answered after fixed wait states
module sst_mem_model #(
  parameter int WAITS = 2
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic        space_y,
  input  wire logic [23:0] addr,
  input  wire logic [23:0] wdata,
  output logic      [23:0] rdata,
  output logic             ack
);
  logic [23:0] mem [0:63];
  int          cnt;
  int          n_wr;
  int          n_rd;
  logic        y_seen;
  // read bus toggles between words so stale data never looks valid
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0; cnt <= 0; n_wr <= 0; n_rd <= 0; y_seen <= 1'b0; rdata <= 24'h000000;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && ack) begin
        cnt <= 0;
        if (we) begin
          mem[addr[5:0]] <= wdata;
          n_wr <= n_wr + 1;
        end else begin
          n_rd <= n_rd + 1;
        end
      end else if (req && cnt == WAITS) begin
        ack <= 1'b1;
        y_seen <= y_seen | space_y;
        if (!we) rdata <= mem[addr[5:0]];
      end else if (req) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// [tb/sst_stack_monitor.sv]
`timescale 1ns/1ps
module sst_stack_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic        op_ready,
  input wire logic        program_counter_load,
  input wire logic        status_word_load,
  input wire logic        spill_enable_bit,
  input wire logic        spill_memory_select,
  input wire logic [23:0] top_of_stack_index,
  input wire logic        stack_error,
  input wire logic        mem_req,
  input wire logic        mem_space_y,
  input wire logic [23:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic        mem_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire take = op_valid && op_ready;
  // pulls seen at the sequencer side
  sequence s_pull_taken;
    take && (op_code == sst_pkg::OP_RET_SUB || op_code == sst_pkg::OP_RET_INT || op_code == sst_pkg::OP_RD_HIGH);
  endsequence
  // a memory word still waiting for its acknowledge
  sequence s_word_wait;
    mem_req && !mem_ack;
  endsequence
  a_call_index_up: assert property (
    take && op_code == sst_pkg::OP_CALL && !spill_enable_bit && top_of_stack_index < 24'h00000f
    |=> top_of_stack_index == $past(top_of_stack_index) + 24'h000001) else $error("call index step wrong");
  a_pull_empty_err: assert property (
    s_pull_taken ##0 top_of_stack_index == 24'h000000 |=> stack_error) else $error("empty pull not flagged");
  a_noext_over_err: assert property (
    take && op_code == sst_pkg::OP_CALL && !spill_enable_bit && top_of_stack_index == 24'h00000f
    |=> stack_error && $stable(top_of_stack_index)) else $error("sixteenth entry accepted");
  a_ret_sub_pc: assert property (
    take && op_code == sst_pkg::OP_RET_SUB && top_of_stack_index != 24'h000000
    |=> program_counter_load && !status_word_load) else $error("return sub loads wrong");
  a_ret_int_both: assert property (
    take && op_code == sst_pkg::OP_RET_INT && top_of_stack_index != 24'h000000
    |=> program_counter_load && status_word_load) else $error("return int loads wrong");
  a_low_keeps_idx: assert property (
    take && (op_code == sst_pkg::OP_WR_LOW || op_code == sst_pkg::OP_RD_LOW)
    |=> $stable(top_of_stack_index)) else $error("low half moved index");
  a_no_spill_off: assert property (
    !spill_enable_bit |-> !mem_req) else $error("memory used with extension off");
  a_space_follows: assert property (
    mem_req |-> mem_space_y == spill_memory_select) else $error("wrong memory space");
  a_word_holds: assert property (
    s_word_wait |=> mem_req && $stable(mem_addr) && $stable(mem_wdata)) else $error("word dropped before ack");
  a_seq_held: assert property (
    mem_req |-> !op_ready) else $error("sequencer not held off");
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t %s", $time, m); end end
module tb;
  logic        clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, op_ready;
  logic [2:0]  op_code = 3'h0;
  logic [23:0] pc_in = 24'h0, sw_in = 24'h0, lc_in = 24'h0, le_in = 24'h0, mv_in = 24'h0;
  logic [23:0] pc_out, sw_out, mv_out, idx, mem_addr, mem_wdata, mem_rdata;
  logic        pc_ld, sw_ld, mv_vld, err, mem_req, mem_we, mem_y, mem_ack;
  logic        sp_en = 1'b0, sp_sel = 1'b0;
  logic [23:0] sz = 24'h000000;
  int          n_mismatch = 0, total_checks = 0;
  always #2 clk = ~clk;
  sst_stack uut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .program_counter_in(pc_in), .status_word_in(sw_in), .loop_count_in(lc_in), .loop_end_address_in(le_in),
    .move_data_in(mv_in), .program_counter_out(pc_out), .program_counter_load(pc_ld), .status_word_out(sw_out),
    .status_word_load(sw_ld), .move_data_out(mv_out), .move_data_valid(mv_vld), .spill_enable_bit(sp_en),
    .spill_memory_select(sp_sel), .stack_size_reg(sz), .top_of_stack_index(idx), .stack_error(err),
    .mem_req(mem_req), .mem_we(mem_we), .mem_space_y(mem_y), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  sst_mem_model #(.WAITS(2)) mdl (.clk(clk), .arst_n(arst_n), .req(mem_req), .we(mem_we), .space_y(mem_y),
    .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
  // one request, held until taken; returns where the answer pulses stand
  // a ready that never comes is counted, not silently skipped
  task automatic wait_ready();
    for (int i = 0; i < 64 && op_ready !== 1'b1; i++) @(negedge clk);
    `CHK(op_ready, 1'b1, "ready timeout")
  endtask
  task automatic op(input logic [2:0] c, input logic [23:0] a, input logic [23:0] b);
    @(posedge clk);
    op_valid <= 1'b1; op_code <= c; pc_in <= a; mv_in <= a; sw_in <= b; le_in <= ~a; lc_in <= ~b;
    @(negedge clk);
    wait_ready();
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic t_call_return();
    op(sst_pkg::OP_CALL, 24'h0000a1, 24'h0000b1);
    `CHK(idx, 24'h000001, "call index")
    op(sst_pkg::OP_RET_INT, 24'h0, 24'h0);
    `CHK({pc_ld, sw_ld, pc_out, sw_out}, {2'b11, 24'h0000a1, 24'h0000b1}, "ret int")
    op(sst_pkg::OP_CALL, 24'h0000a2, 24'h0000b2);
    op(sst_pkg::OP_RET_SUB, 24'h0, 24'h0);
    `CHK({pc_ld, sw_ld, pc_out, sw_out, idx}, {2'b10, 24'h0000a2, 24'h0000b1, 24'h0}, "ret sub")
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK({err, idx}, {1'b1, 24'h0}, "empty pull")
  endtask
  task automatic t_loop_moves();
    op(sst_pkg::OP_LOOP, 24'h0000c3, 24'h0000c4);
    wait_ready();
    `CHK(idx, 24'h000002, "loop index")
    op(sst_pkg::OP_RD_LOW, 24'h0, 24'h0);
    `CHK({mv_vld, mv_out, idx}, {1'b1, 24'h0000c4, 24'h000002}, "loop status")
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK({mv_out, idx}, {24'h0000c3, 24'h000001}, "loop first addr")
    op(sst_pkg::OP_RD_LOW, 24'h0, 24'h0);
    `CHK(mv_out, 24'hffff3b, "loop count")
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK({mv_out, idx}, {24'hffff3c, 24'h0}, "loop end addr")
    op(sst_pkg::OP_WR_HIGH, 24'h0000d1, 24'h0);
    op(sst_pkg::OP_WR_LOW, 24'h0000d2, 24'h0);
    `CHK(idx, 24'h000001, "moves index")
    op(sst_pkg::OP_RET_INT, 24'h0, 24'h0);
    `CHK({pc_out, sw_out}, {24'h0000d1, 24'h0000d2}, "moved halves")
  endtask
  task automatic t_noext_full();
    for (int i = 1; i <= 15; i++) op(sst_pkg::OP_CALL, 24'h100000 | 24'(i), 24'h0);
    `CHK(idx, 24'h00000f, "fifteen entries")
    op(sst_pkg::OP_CALL, 24'h0000ee, 24'h0);
    `CHK({err, idx}, {1'b1, 24'h00000f}, "overflow")
    for (int i = 15; i >= 1; i--) begin
      op(sst_pkg::OP_RET_SUB, 24'h0, 24'h0);
      `CHK(pc_out, 24'h100000 | 24'(i), "lifo order")
    end
  endtask
  // extension into Y space with wait states; four entry spills then four entry fills
  task automatic t_ext_spill();
    @(posedge clk);
    sp_en <= 1'b1; sp_sel <= 1'b1; sz <= 24'h000010;
    for (int i = 1; i <= 16; i++) op(sst_pkg::OP_CALL, 24'h200000 | 24'(i), 24'h300000 | 24'(i));
    wait_ready();
    `CHK(mdl.n_wr, 4, "spill words")
    `CHK({mdl.mem[0], mdl.mem[1], mdl.mem[3]}, {24'h200001, 24'h300001, 24'h300002}, "spill order")
    `CHK(mdl.y_seen, 1'b1, "y space")
    op(sst_pkg::OP_CALL, 24'h0000ee, 24'h0);
    `CHK(err, 1'b1, "ext limit")
    // a loop push on a full on-chip stack moves two entries
    @(posedge clk);
    sz <= 24'h000012;
    op(sst_pkg::OP_LOOP, 24'h0000c5, 24'h0000c6);
    wait_ready();
    `CHK({mdl.n_wr, mdl.mem[4], mdl.mem[7]}, {32'd8, 24'h200003, 24'h300004}, "two-entry spill")
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK(mv_out, 24'h0000c5, "ext loop first addr")
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK({mv_out, idx}, {24'hffff3a, 24'h000010}, "ext loop end addr")
    for (int i = 16; i >= 1; i--) begin
      op(sst_pkg::OP_RET_INT, 24'h0, 24'h0);
      `CHK({pc_out, sw_out}, {24'h200000 | 24'(i), 24'h300000 | 24'(i)}, "fill data")
    end
    wait_ready();
    `CHK({mdl.n_rd, idx}, {32'd8, 24'h0}, "fill words")
    @(posedge clk);
    sp_en <= 1'b0;
  endtask
  // reset in mid-run empties a non-empty stack
  task automatic t_reset_mid();
    op(sst_pkg::OP_CALL, 24'h0000a5, 24'h0000b5);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    `CHK({idx, op_ready, mem_req}, {24'h0, 1'b1, 1'b0}, "reset state")
    @(posedge clk);
    arst_n <= 1'b1;
    op(sst_pkg::OP_RD_HIGH, 24'h0, 24'h0);
    `CHK({err, idx}, {1'b1, 24'h0}, "empty after reset")
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_call_return();
    t_loop_moves();
    t_noext_full();
    t_ext_spill();
    t_reset_mid();
    finish_test();
  end
  // whole run needs a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
bind sst_stack sst_stack_monitor mon (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
  .op_ready(op_ready), .program_counter_load(program_counter_load), .status_word_load(status_word_load),
  .spill_enable_bit(spill_enable_bit), .spill_memory_select(spill_memory_select),
  .top_of_stack_index(top_of_stack_index), .stack_error(stack_error), .mem_req(mem_req),
  .mem_space_y(mem_space_y), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
